// *** rtl/gpp_pkg.sv ***
// Constants for the general port group: widths, register indices and reset values.
// Assumes a single 250 MHz clock domain and the processor's internal port access.
`default_nettype none
package gpp_pkg;
    // ==========================================================
    // Port widths
    localparam int GPP_P0_W = 5;
    localparam int GPP_P7_W = 5;
    localparam int GPP_P8_W = 2;
    localparam int GPP_BYTE_W = 8;
    // ==========================================================
    // Port select codes used on the internal access port
    localparam logic [3:0] GPP_SEL_P0 = 4'h0;
    localparam logic [3:0] GPP_SEL_P1 = 4'h1;
    localparam logic [3:0] GPP_SEL_P2 = 4'h2;
    localparam logic [3:0] GPP_SEL_P3 = 4'h3;
    localparam logic [3:0] GPP_SEL_P7 = 4'h7;
    localparam logic [3:0] GPP_SEL_P8 = 4'h8;
    localparam logic [3:0] GPP_SEL_P9 = 4'h9;
    localparam logic [3:0] GPP_SEL_P10 = 4'hA;
    localparam logic [3:0] GPP_SEL_P11 = 4'hB;
    localparam logic [3:0] GPP_SEL_P12 = 4'hC;
    // ==========================================================
    // Reset values
    localparam logic [7:0] GPP_DIR_RST_SHORT = 8'h1F;
    localparam logic [7:0] GPP_DIR_RST = 8'hFF;
    localparam logic [7:0] GPP_LATCH_RST = 8'h00;
    localparam logic [7:0] GPP_PULLUP_RST = 8'h00;
    // ==========================================================
    // Pull-up option bit positions
    localparam int GPP_PU_P0 = 0;
    localparam int GPP_PU_P1 = 1;
    localparam int GPP_PU_P2 = 2;
    localparam int GPP_PU_P3 = 3;
    // ==========================================================
    // Pin synchroniser depth
    localparam int GPP_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// *** rtl/gpp_ports.sv ***
// General parallel port group: direction registers, latches, pull-ups and alternates.
// Assumes the processor drives one access per cycle and pins come from outside the clock.
`default_nettype none
module gpp_ports
    import gpp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,

    // Processor access port.
    input wire logic [3:0] acc_port,
    input wire logic acc_dir,
    input wire logic acc_pullup,
    input wire logic acc_wr,
    input wire logic acc_bit,
    input wire logic [2:0] acc_bit_idx,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] acc_rdata,

    // Pins.
    input wire logic [4:0] p0_in,
    output logic [4:0] p0_out,
    output logic [4:0] p0_oe,
    output logic [4:0] p0_pullup,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p1_pullup,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    output logic [7:0] p2_pullup,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe,
    output logic [7:0] p3_pullup,
    input wire logic [4:0] p7_in,
    output logic [4:0] p7_out,
    output logic [4:0] p7_oe,
    output logic [1:0] p8_out,
    output logic [1:0] p8_oe,
    output logic [7:0] p9_out,
    output logic [7:0] p9_oe,
    output logic [7:0] p10_out,
    output logic [7:0] p10_oe,
    input wire logic [7:0] p11_in,
    output logic [7:0] p11_out,
    output logic [7:0] p11_oe,
    input wire logic [7:0] p12_in,
    output logic [7:0] p12_out,
    output logic [7:0] p12_oe,

    // Alternate functions.
    output logic [3:0] ext_irq_in,
    output logic [3:0] ext_irq_req,
    output logic timer_count_in_0,
    output logic capture_in_0,
    output logic subclock_crystal_in,
    input wire logic [7:0] analog_inputs,
    output logic serial1_data_in,
    input wire logic serial1_data_out_en,
    input wire logic serial1_data_out,
    output logic serial1_clock_in,
    input wire logic serial1_clock_out_en,
    input wire logic serial1_clock_out,
    input wire logic transfer_strobe_en,
    input wire logic transfer_strobe_out,
    output logic transfer_busy_in,
    output logic serial0_data_in_bus0,
    input wire logic serial0_bus0_out_en,
    input wire logic serial0_bus0_out,
    input wire logic serial0_data_out_en,
    input wire logic serial0_data_out_bus1,
    output logic serial0_clock_in,
    input wire logic serial0_clock_out_en,
    input wire logic serial0_clock_out,
    input wire logic [2:0] timer_out_en,
    input wire logic [2:0] timer_out,
    output logic timer_in_1,
    output logic timer_in_2,
    input wire logic clock_out_en,
    input wire logic clock_out_pin,
    input wire logic buzzer_out_en,
    input wire logic buzzer_out_pin,
    input wire logic [1:0] display_drive_en8,
    input wire logic [1:0] display_drive_out,
    input wire logic [7:0] display_drive_en9,
    input wire logic [7:0] display_drive_p9,
    input wire logic [7:0] display_drive_en10,
    input wire logic [7:0] display_drive_p10,
    input wire logic [7:0] display_drive_en11,
    input wire logic [7:0] display_drive_p11,
    input wire logic [7:0] display_drive_en12,
    input wire logic [7:0] display_drive_p12
);
    // ==========================================================
    // Pin synchronisers: three stages, change accepted when two and three agree.
    localparam int PW = 53;
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] s1_r;
    logic [PW-1:0] s2_r;
    logic [PW-1:0] s3_r;
    logic [PW-1:0] pin_r;
    logic [PW-1:0] pin_nxt;
    assign pin_raw = {p12_in, p11_in, p7_in, p3_in, p2_in, p1_in, p0_in, 3'h0};
    // A pin level is taken once stages two and three agree; otherwise it holds.
    assign pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    logic [4:0] p0_pin;
    logic [7:0] p1_pin;
    logic [7:0] p2_pin;
    logic [7:0] p3_pin;
    logic [4:0] p7_pin;
    logic [7:0] p11_pin;
    logic [7:0] p12_pin;
    assign p0_pin = pin_r[7:3];
    assign p1_pin = pin_r[15:8];
    assign p2_pin = pin_r[23:16];
    assign p3_pin = pin_r[31:24];
    assign p7_pin = pin_r[36:32];
    assign p11_pin = pin_r[44:37];
    assign p12_pin = pin_r[52:45];

    // ==========================================================
    // Registers.
    logic [7:0] dir_r [0:12];
    logic [7:0] lat_r [0:12];
    logic [7:0] pullup_option_reg_r;
    wire [7:0] bit_mask = 8'h01 << acc_bit_idx;
    wire [7:0] wmask = acc_bit ? bit_mask : 8'hFF;
    wire wr_dir = acc_wr && acc_dir;
    wire wr_lat = acc_wr && !acc_dir && !acc_pullup;
    wire wr_pu = acc_wr && acc_pullup;
    wire [3:0] sel = acc_port;
    wire has_dir = (sel == GPP_SEL_P0) || (sel == GPP_SEL_P1) || (sel == GPP_SEL_P2)
        || (sel == GPP_SEL_P3) || (sel == GPP_SEL_P7) || (sel == GPP_SEL_P11)
        || (sel == GPP_SEL_P12);
    function automatic logic [7:0] dir_fix(input logic [3:0] p, input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (p == GPP_SEL_P0) begin
            r = {3'h0, 1'b1, v[3:1], 1'b1};
        end
        if (p == GPP_SEL_P7) begin
            r = {3'h0, v[4:0]};
        end
        return r;
    endfunction

    // Merged write values: a bit access changes only the indexed bit.
    wire lat_ok = sel <= GPP_SEL_P12;
    wire dir_we = wr_dir && has_dir;
    wire lat_we = wr_lat && lat_ok;
    logic [7:0] dir_nxt;
    logic [7:0] lat_nxt;
    logic [7:0] pullup_option_nxt;
    assign dir_nxt = dir_fix(sel, (dir_r[sel] & ~wmask) | (acc_wdata & wmask));
    assign lat_nxt = (lat_r[sel] & ~wmask) | (acc_wdata & wmask);
    assign pullup_option_nxt = (pullup_option_reg_r & ~wmask) | (acc_wdata & wmask);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i <= 12; i++) begin
                dir_r[i] <= (i == 0 || i == 7) ? GPP_DIR_RST_SHORT : GPP_DIR_RST;
                lat_r[i] <= GPP_LATCH_RST;
            end
            pullup_option_reg_r <= GPP_PULLUP_RST;
        end else begin
            if (dir_we)
                dir_r[sel] <= dir_nxt;
            if (lat_we)
                lat_r[sel] <= lat_nxt;
            if (wr_pu)
                pullup_option_reg_r <= pullup_option_nxt;
        end
    end

    // ==========================================================
    // Pin drive: direction one is input (driver off), alternates override latch.
    logic [7:0] p2_alt_en;
    logic [7:0] p2_alt_v;
    logic [7:0] p3_alt_en;
    logic [7:0] p3_alt_v;
    assign p2_alt_en = {serial0_clock_out_en, serial0_data_out_en, serial0_bus0_out_en, 1'b0,
        transfer_strobe_en, serial1_clock_out_en, serial1_data_out_en, 1'b0};
    assign p2_alt_v = {serial0_clock_out, serial0_data_out_bus1, serial0_bus0_out, 1'b0,
        transfer_strobe_out, serial1_clock_out, serial1_data_out, 1'b0};
    assign p3_alt_en = {1'b0, buzzer_out_en, clock_out_en, 2'h0, timer_out_en};
    assign p3_alt_v = {1'b0, buzzer_out_pin, clock_out_pin, 2'h0, timer_out};
    assign p0_oe = ~dir_r[0][4:0];
    assign p0_out = lat_r[0][4:0];
    assign p1_oe = ~dir_r[1];
    assign p1_out = lat_r[1];
    assign p2_oe = ~dir_r[2];
    assign p2_out = (p2_alt_en & p2_alt_v) | (~p2_alt_en & lat_r[2]);
    assign p3_oe = ~dir_r[3];
    assign p3_out = (p3_alt_en & p3_alt_v) | (~p3_alt_en & lat_r[3]);

    // Open-drain: drive low only where output mode and data is zero.
    assign p7_out = 5'h00;
    assign p7_oe = ~dir_r[7][4:0] & ~lat_r[7][4:0];

    // Ports 8-10 are output only; ports 11 and 12 reset to input mode and drive only where direction is zero.
    logic [1:0] p8_v;
    logic [7:0] p9_v;
    logic [7:0] p10_v;
    logic [7:0] p11_v;
    logic [7:0] p12_v;
    assign p8_v = (display_drive_en8 & display_drive_out) | (~display_drive_en8 & lat_r[8][1:0]);
    assign p9_v = (display_drive_en9 & display_drive_p9) | (~display_drive_en9 & lat_r[9]);
    assign p10_v = (display_drive_en10 & display_drive_p10) | (~display_drive_en10 & lat_r[10]);
    assign p11_v = (display_drive_en11 & display_drive_p11) | (~display_drive_en11 & lat_r[11]);
    assign p12_v = (display_drive_en12 & display_drive_p12) | (~display_drive_en12 & lat_r[12]);
    logic [7:0] p11_drv;
    logic [7:0] p12_drv;
    assign p11_drv = ~dir_r[11] & p11_v;
    assign p12_drv = ~dir_r[12] & p12_v;

    // P-channel open-drain: drive high where data is one.
    assign p8_out = 2'h3;
    assign p8_oe = p8_v;
    assign p9_out = 8'hFF;
    assign p9_oe = p9_v;
    assign p10_out = 8'hFF;
    assign p10_oe = p10_v;
    assign p11_out = 8'hFF;
    assign p11_oe = p11_drv;
    assign p12_out = 8'hFF;
    assign p12_oe = p12_drv;

    // ==========================================================
    // Pull-ups: input mode and group enable, never on analog pins.
    assign p0_pullup = {1'b0, {3{pullup_option_reg_r[GPP_PU_P0]}} & dir_r[0][3:1], 1'b0};
    assign p1_pullup = {8{pullup_option_reg_r[GPP_PU_P1]}} & dir_r[1] & ~analog_inputs;
    assign p2_pullup = {8{pullup_option_reg_r[GPP_PU_P2]}} & dir_r[2];
    assign p3_pullup = {8{pullup_option_reg_r[GPP_PU_P3]}} & dir_r[3];

    // ==========================================================
    // Alternate inputs.
    assign ext_irq_in = p0_pin[3:0];
    assign timer_count_in_0 = p0_pin[0];
    assign capture_in_0 = p0_pin[3];
    assign subclock_crystal_in = p0_pin[4];
    assign serial1_data_in = p2_pin[0];
    assign serial1_clock_in = p2_pin[2];
    assign transfer_busy_in = p2_pin[4];
    assign serial0_data_in_bus0 = p2_pin[5];
    assign serial0_clock_in = p2_pin[7];
    assign timer_in_1 = p3_pin[3];
    assign timer_in_2 = p3_pin[4];

    // Interrupt request on any level change of port 0 bits 0-3, including driven ones.
    logic [3:0] irq_prev_r;
    logic [3:0] irq_req_r;
    logic [3:0] irq_level;
    logic [3:0] irq_req_nxt;
    assign irq_level = (p0_oe[3:0] & p0_out[3:0]) | (~p0_oe[3:0] & p0_pin[3:0]);
    // A change in either direction gives a one-cycle request.
    assign irq_req_nxt = irq_level ^ irq_prev_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_prev_r <= 4'h0;
            irq_req_r <= 4'h0;
        end else begin
            irq_prev_r <= irq_level;
            irq_req_r <= irq_req_nxt;
        end
    end
    assign ext_irq_req = irq_req_r;

    // ==========================================================
    // Read path: pin in input mode, latch in output mode.
    logic [7:0] rd_pin;
    logic [7:0] rd_dir;
    logic [7:0] rd_lat;
    always_comb begin
        rd_pin = 8'h00;
        unique case (sel)
            GPP_SEL_P0: rd_pin = {3'h0, p0_pin};
            GPP_SEL_P1: rd_pin = p1_pin;
            GPP_SEL_P2: rd_pin = p2_pin;
            GPP_SEL_P3: rd_pin = p3_pin;
            GPP_SEL_P7: rd_pin = {3'h0, p7_pin};
            GPP_SEL_P11: rd_pin = p11_pin;
            GPP_SEL_P12: rd_pin = p12_pin;
            default: rd_pin = 8'h00;
        endcase
    end
    assign rd_dir = has_dir ? dir_r[sel] : 8'h00;
    assign rd_lat = lat_ok ? lat_r[sel] : 8'h00;
    logic [7:0] rd_port;
    assign rd_port = (rd_dir & rd_pin) | (~rd_dir & rd_lat);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_rdata <= 8'h00;
        end else if (acc_dir) begin
            acc_rdata <= rd_dir;
        end else if (acc_pullup) begin
            acc_rdata <= pullup_option_reg_r;
        end else begin
            acc_rdata <= rd_port;
        end
    end
endmodule
`default_nettype wire

// *** testbench/gpp_ports_sva.sv ***
// Checker for the general port group, watching the top module's ports.
// Assumes one clock domain and the package select codes.
`default_nettype none
module gpp_ports_sva
    import gpp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] acc_port,
    input wire logic acc_dir,
    input wire logic acc_pullup,
    input wire logic acc_wr,
    input wire logic acc_bit,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] acc_rdata,
    input wire logic [4:0] p0_oe,
    input wire logic [4:0] p0_pullup,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p1_pullup,
    input wire logic [7:0] analog_inputs,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [2:0] timer_out_en,
    input wire logic [2:0] timer_out,
    input wire logic [3:0] ext_irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic p1_sel;
    assign p1_sel = !acc_pullup && !acc_bit && acc_port == GPP_SEL_P1;
    dir_to_oe_a: assert property (p1_sel && acc_wr && acc_dir |=> p1_oe == ~$past(acc_wdata))
        else $error("port 1 enable does not follow direction write");
    latch_write_a: assert property (p1_sel && acc_wr && !acc_dir |=> p1_out == $past(acc_wdata))
        else $error("port 1 latch not written");
    latch_read_a: assert property (p1_sel && !acc_wr && !acc_dir && p1_oe == 8'hFF |=> acc_rdata == $past(p1_out))
        else $error("output mode read is not the latch");
    pull_input_a: assert property ((p1_pullup & p1_oe) == 8'h00 && (p0_pullup & p0_oe) == 5'h00)
        else $error("pull-up on an output pin");
    pull_analog_a: assert property ((p1_pullup & analog_inputs) == 8'h00)
        else $error("pull-up on an analog pin");
    p0_share_a: assert property (p0_oe == 5'h00 |-> p0_pullup == 5'h00 || p0_pullup == 5'h0E)
        else $error("port 0 pull-ups not shared");
    p0_fixed_a: assert property (p0_oe[0] == 1'b0 && p0_oe[4] == 1'b0)
        else $error("port 0 input-only bit driven");
    dir0_read_a: assert property (acc_dir && !acc_pullup && acc_port == GPP_SEL_P0 |=> acc_rdata[7:5] == 3'h0 && acc_rdata[4] && acc_rdata[0])
        else $error("port 0 direction fixed bits wrong");
    alt_timer_a: assert property (timer_out_en[0] && p3_oe[0] |-> p3_out[0] == timer_out[0])
        else $error("timer output not routed");
    irq_pulse_a: assert property (ext_irq_req[1] |=> !ext_irq_req[1])
        else $error("interrupt request longer than one cycle");
endmodule
bind gpp_ports gpp_ports_sva gpp_ports_sva_inst (.*);
`default_nettype wire

// *** testbench/gpp_board.sv ***
// Board model for one port: resolves each pin from the device, a board driver and pull-ups.
// Assumes the device enable means drive; a floating pin shows the inverse of its last level.
`default_nettype none
module gpp_board #(parameter int W = 8) (
    input wire logic clock,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pu,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating pin holds the inverse of its last driven level, steadily.
    logic [W-1:0] last_r = '0;
    always_ff @(posedge clock) begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i] || ext_en[i]) last_r[i] <= pin_in[i];
        end
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pu[i] | ~last_r[i];
        end
    end
endmodule
`default_nettype wire

// *** testbench/gpp_ports_tb.sv ***
// Self-checking bench for the general port group.
// Assumes the board model on ports 0, 1, 3 and 7; other pins are driven here.
`default_nettype none
module gpp_ports_tb;
    import gpp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, acc_dir, acc_pullup, acc_wr, acc_bit;
    logic [3:0] acc_port, ext_irq_in, ext_irq_req;
    logic [2:0] acc_bit_idx, timer_out_en, timer_out;
    logic [7:0] acc_wdata, acc_rdata, analog_inputs, e1v, e1e, rv;
    logic [4:0] p0_in, p0_out, p0_oe, p0_pullup, p7_in, p7_out, p7_oe;
    logic [7:0] p1_in, p1_out, p1_oe, p1_pullup, p2_in, p2_out, p2_oe, p2_pullup;
    logic [7:0] p3_in, p3_out, p3_oe, p3_pullup, p9_out, p9_oe, p10_out, p10_oe;
    logic [7:0] p11_in, p11_out, p11_oe, p12_in, p12_out, p12_oe;
    logic [1:0] p8_out, p8_oe, display_drive_en8, display_drive_out;
    logic timer_count_in_0, capture_in_0, subclock_crystal_in, serial1_data_in, serial1_data_out_en;
    logic serial1_data_out, serial1_clock_in, serial1_clock_out_en, serial1_clock_out;
    logic transfer_strobe_en, transfer_strobe_out, transfer_busy_in, serial0_data_in_bus0;
    logic serial0_bus0_out_en, serial0_bus0_out, serial0_data_out_en, serial0_data_out_bus1;
    logic serial0_clock_in, serial0_clock_out_en, serial0_clock_out, timer_in_1, timer_in_2;
    logic clock_out_en, clock_out_pin, buzzer_out_en, buzzer_out_pin;
    logic [7:0] display_drive_en9, display_drive_p9, display_drive_en10, display_drive_p10;
    logic [7:0] display_drive_en11, display_drive_p11, display_drive_en12, display_drive_p12;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    gpp_ports gpp_ports_inst (.*);
    gpp_board #(.W(5)) b0 (.clock(clock), .pin_out(p0_out), .pin_oe(p0_oe), .pin_pu(p0_pullup),
        .ext_val(5'h00), .ext_en(5'h00), .pin_in(p0_in));
    gpp_board b1 (.clock(clock), .pin_out(p1_out), .pin_oe(p1_oe), .pin_pu(p1_pullup),
        .ext_val(e1v), .ext_en(e1e), .pin_in(p1_in));
    gpp_board b3 (.clock(clock), .pin_out(p3_out), .pin_oe(p3_oe), .pin_pu(p3_pullup),
        .ext_val(e1v), .ext_en(e1e), .pin_in(p3_in));
    gpp_board #(.W(5)) b7 (.clock(clock), .pin_out(p7_out), .pin_oe(p7_oe), .pin_pu(5'h00),
        .ext_val(e1v[4:0]), .ext_en(e1e[4:0]), .pin_in(p7_in));
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] pt, input logic d, pu, b, input logic [2:0] ix,
        input logic [7:0] v);
        {acc_port, acc_dir, acc_pullup, acc_bit, acc_bit_idx, acc_wdata} = {pt, d, pu, b, ix, v};
        acc_wr = 1'b1;
        @(negedge clock);
        acc_wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [3:0] pt, input logic d);
        {acc_port, acc_dir, acc_pullup} = {pt, d, 1'b0};
        @(negedge clock);
        rv = acc_rdata;
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(p0_oe, 8'h00);
        chk(p1_oe | p2_oe | p3_oe, 8'h00);
        rd(GPP_SEL_P0, 1'b1);
        chk(rv, 8'h1F);
        rd(GPP_SEL_P7, 1'b1);
        chk(rv, 8'h1F);
        rd(GPP_SEL_P2, 1'b1);
        chk(rv, 8'hFF);
    endtask
    task automatic t_port1();
        e1v = 8'h3C;
        e1e = 8'hFF;
        wr(GPP_SEL_P1, 1'b0, 1'b0, 1'b0, 3'h0, 8'hA5);
        chk(p1_oe, 8'h00);
        chk(p1_in, 8'h3C);
        repeat (6) @(negedge clock);
        rd(GPP_SEL_P1, 1'b0);
        chk(rv, 8'h3C);
        wr(GPP_SEL_P1, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        chk(p1_oe, 8'hFF);
        chk(p1_out, 8'hA5);
        rd(GPP_SEL_P1, 1'b0);
        chk(rv, 8'hA5);
        wr(GPP_SEL_P1, 1'b1, 1'b0, 1'b1, 3'h3, 8'h08);
        chk(p1_oe, 8'hF7);
        wr(GPP_SEL_P1, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00);
        chk(p1_out, 8'hA4);
        repeat (6) @(negedge clock);
        rd(GPP_SEL_P1, 1'b0);
        chk(rv, 8'hAC);
    endtask
    task automatic t_pull();
        e1e = 8'h00;
        wr(GPP_SEL_P1, 1'b1, 1'b0, 1'b0, 3'h0, 8'hFF);
        wr(GPP_SEL_P0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h0F);
        chk(p1_pullup, 8'hFF);
        chk(p0_pullup, 8'h0E);
        analog_inputs = 8'h0F;
        @(negedge clock);
        chk(p1_pullup, 8'hF0);
        wr(GPP_SEL_P1, 1'b1, 1'b0, 1'b0, 3'h0, 8'h0F);
        chk(p1_pullup, 8'h00);
        analog_inputs = 8'h00;
    endtask
    task automatic t_irq();
        logic got;
        got = 1'b0;
        wr(GPP_SEL_P0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        chk(p0_oe, 8'h0E);
        wr(GPP_SEL_P0, 1'b0, 1'b0, 1'b0, 3'h0, 8'h02);
        for (int i = 0; i < 10; i++) begin
            got |= ext_irq_req[1];
            @(negedge clock);
        end
        chk(got, 1'b1);
    endtask
    task automatic t_alt();
        wr(GPP_SEL_P3, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        {timer_out_en, timer_out} = 6'h09;
        @(negedge clock);
        chk(p3_out[0], 1'b1);
        wr(GPP_SEL_P8, 1'b0, 1'b0, 1'b0, 3'h0, 8'h01);
        chk(p8_oe, 8'h01);
        {display_drive_en8, display_drive_out} = 4'hA;
        @(negedge clock);
        chk(p8_oe, 8'h03);
        wr(GPP_SEL_P7, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        chk(p7_oe, 8'h1F);
        wr(GPP_SEL_P9, 1'b0, 1'b0, 1'b0, 3'h0, 8'h81);
        chk(p9_oe, 8'h81);
        wr(GPP_SEL_P11, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
        wr(GPP_SEL_P11, 1'b0, 1'b0, 1'b0, 3'h0, 8'h0F);
        chk(p11_oe, 8'h0F);
        serial1_data_out_en = 1'b1;
        serial1_data_out = 1'b1;
        p2_in = 8'h20;
        wr(GPP_SEL_P2, 1'b1, 1'b0, 1'b0, 3'h0, 8'hFD);
        chk(p2_oe, 8'h02);
        chk(p2_out, 8'h02);
        repeat (4) @(negedge clock);
        chk(serial0_data_in_bus0, 1'b1);
        rd(GPP_SEL_P2, 1'b0);
        chk(rv, 8'h20);
    endtask
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {acc_port, acc_dir, acc_pullup, acc_wr, acc_bit, acc_bit_idx, acc_wdata} = '0;
        {analog_inputs, e1v, e1e, p2_in, p11_in, p12_in, timer_out_en, timer_out} = '0;
        {serial1_data_out_en, serial1_data_out, serial1_clock_out_en, serial1_clock_out} = '0;
        {transfer_strobe_en, transfer_strobe_out, serial0_bus0_out_en, serial0_bus0_out} = '0;
        {serial0_data_out_en, serial0_data_out_bus1, serial0_clock_out_en, serial0_clock_out} = '0;
        {clock_out_en, clock_out_pin, buzzer_out_en, buzzer_out_pin} = '0;
        {display_drive_en8, display_drive_out, display_drive_en9, display_drive_p9} = '0;
        {display_drive_en10, display_drive_p10, display_drive_en11, display_drive_p11} = '0;
        {display_drive_en12, display_drive_p12} = '0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_port1();
        t_pull();
        t_irq();
        t_alt();
        tally_and_finish();
    end
endmodule
`default_nettype wire
